/* inc/cbc_pkg.sv */
// constants and types for the band compare and capture block
package cbc_pkg;
  localparam int NUM_ITEMS = 4;
  localparam int NUM_FLAGS = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] HOLD_MAX_MS = 10'h3E8;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_SAMP = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_CAP0 = 8'h10;
  localparam logic [7:0] OFS_CAP1 = 8'h14;
  localparam logic [7:0] OFS_DIFF = 8'h18;
  localparam logic [7:0] OFS_COUNT = 8'h1C;
  localparam logic [1:0] OFS_ITEM_HI2 = 2'h1;
  localparam int C_CAP_EN = 0;
  localparam int C_SAMP = 1;
  localparam int C_CONT = 2;
  localparam int C_STRG = 3;
  localparam int C_SRC0 = 5;
  localparam int C_EDGE0 = 6;
  localparam int C_ROUTE0 = 9;
  localparam int C_FEN0 = 11;
  localparam int C_FVAL0 = 12;
  localparam int C_BAND = 15;
  typedef enum logic [1:0] {
    CBC_ST_CTL_HI = 2'b00,
    CBC_ST_CTL_LO = 2'b01,
    CBC_ST_ENBIT = 2'b10
  } cbc_strg_e;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [9:0] hold_ms;
    logic [15:0] samp_ms;
    logic [NUM_ITEMS-1:0][31:0] lo;
    logic [NUM_ITEMS-1:0][31:0] hi;
    logic [NUM_ITEMS-1:0][31:0] act;
    logic [NUM_FLAGS-1:0] flags;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [16:0] ms_cnt;
    logic [1:0][10:0] hold_cnt;
    logic [1:0] ext;
    logic en_q;
    logic [1:0] arm;
    logic [1:0] wr;
    logic [1:0] done;
    logic [1:0] stat;
    logic [31:0] cap0;
    logic [31:0] cap1;
    logic [31:0] diff;
    logic samp_run;
    logic [16:0] samp_cnt;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } cbc_state_s;
endpackage : cbc_pkg

/* core/cbc_top.sv */
// band compare, external output and capture logic for one counter channel
`timescale 1ns/1ns
// Operation
// - sixteen match flags, each item sets any of them ON or OFF
// - several items may cover one band; each is evaluated on its own
// - count inside an item's limits drives its assigned flags to its values
// - lower limit above upper limit makes the band wrap across rollover
// - match flags 0 and 1 may be routed to external outputs 0 and 1
// - hold zero follows the flag; 1 to 1000 ms turns each assertion into a pulse of that length
// - force bits drive either external output ON or OFF over comparison
// - capture mode latches count into capture 0 or 1 on its input edge
// - sampling mode stores count into capture 0 at start and capture 1 after sampling time
// - difference register shows the count gained during sampling time
// - two capture points, one sampling point; sampling excludes capture
// - capture words are independent in capture mode, paired in sampling
// - capture needs enable held ON; sampling is armed without enable
// - either input triggers either capture; only input 0 starts sampling
// - triggers qualify on rising or falling edge; both edges via two slots
// - sampling start: input 0 rising, input 0 falling, or enable bit rising
// - completion status bits clear automatically at every I/O refresh
// - single shot takes one capture per word, on its first edge after enable
// - captured values are signed 32-bit two's complement numbers
module cbc_top #(
  parameter int MS_CYC = cbc_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ctl_in,
  input wire logic signed [31:0] count,
  input wire logic io_refresh,
  output logic [1:0] ext_out,
  output logic [cbc_pkg::NUM_FLAGS-1:0] match_flags,
  output logic [1:0] cap_status
);
  import cbc_pkg::*;

  cbc_state_s s_q;
  cbc_state_s n;
  logic tick;
  logic [1:0] chg;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] trig;
  logic en;
  logic en_rise;
  logic samp;
  logic cont;
  logic samp_start;
  logic [NUM_ITEMS-1:0] in_band;
  cbc_strg_e strg;

  assign tick = (s_q.ms_cnt == 17'(MS_CYC - 1));
  // filtered edge once stages two and three agree
  assign chg = ~(s_q.s2 ^ s_q.s3) & (s_q.s3 ^ s_q.lvl);
  assign rise = chg & s_q.s3;
  assign fall = chg & ~s_q.s3;
  assign en = s_q.ctrl[C_CAP_EN];
  assign en_rise = en & ~s_q.en_q;
  assign samp = s_q.ctrl[C_SAMP];
  assign cont = s_q.ctrl[C_CONT];
  assign strg = cbc_strg_e'(s_q.ctrl[C_STRG +: 2]);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_trig
      logic src;
      logic edg;
      assign src = s_q.ctrl[C_SRC0 + 2 * g];
      assign edg = s_q.ctrl[C_EDGE0 + 2 * g];
      assign trig[g] = edg ? fall[src] : rise[src];
    end
    for (g = 0; g < NUM_ITEMS; g++) begin : g_item
      logic signed [31:0] lo;
      logic signed [31:0] hi;
      assign lo = s_q.lo[g];
      assign hi = s_q.hi[g];
      assign in_band[g] = (lo <= hi) ? (count >= lo && count <= hi)
                                     : (count >= lo || count <= hi);
    end
  endgenerate

  always_comb begin
    logic [1:0] dset;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] rd;
    logic hit;
    logic held;
    logic [1:0] idx;
    dset = 2'b00;
    c0 = s_q.cap0;
    c1 = s_q.cap1;
    rd = 32'h0000_0000;
    hit = 1'b1;
    held = 1'b0;
    idx = paddr[5:4];
    samp_start = 1'b0;
    n = s_q;
    n.ms_cnt = tick ? 17'h0_0000 : s_q.ms_cnt + 17'h0_0001;
    n.s1 = ctl_in;
    n.s2 = s_q.s1;
    n.s3 = s_q.s2;
    n.lvl = (s_q.lvl & ~chg) | (s_q.s3 & chg);

    // high index first so item 0 has last word
    if (s_q.ctrl[C_BAND]) begin
      for (int j = NUM_ITEMS - 1; j >= 0; j--) begin
        if (in_band[j]) begin
          n.flags = (n.flags & ~s_q.act[j][31:16])
                  | (s_q.act[j][15:0] & s_q.act[j][31:16]);
        end
      end
    end

    for (int j = 0; j < 2; j++) begin
      if (n.flags[j] && !s_q.flags[j]) begin
        n.hold_cnt[j] = {1'b0, s_q.hold_ms} + 11'h001;
      end else if (tick && s_q.hold_cnt[j] != 11'h000) begin
        n.hold_cnt[j] = s_q.hold_cnt[j] - 11'h001;
      end
      held = (s_q.hold_ms == 10'h000) ? n.flags[j]
                                      : (n.hold_cnt[j] != 11'h000);
      if (s_q.ctrl[C_FEN0 + 2 * j]) begin
        n.ext[j] = s_q.ctrl[C_FVAL0 + 2 * j];
      end else begin
        n.ext[j] = s_q.ctrl[C_ROUTE0 + j] & held;
      end
    end

    n.en_q = en;
    if (!samp) begin
      n.samp_run = 1'b0;
      if (en_rise) begin
        n.arm = 2'b11;
        n.wr = 2'b00;
        n.stat = 2'b00;
      end
      if (en && trig[0] && (cont || s_q.arm[0])) begin
        c0 = count;
        dset[0] = 1'b1;
      end
      if (en && trig[1] && (cont || s_q.arm[1])) begin
        c1 = count;
        dset[1] = 1'b1;
      end
      n.cap0 = c0;
      n.cap1 = c1;
      n.arm = n.arm & ~dset;
      n.wr = n.wr | dset;
      if (dset != 2'b00 && n.wr == 2'b11) begin
        n.diff = c1 - c0;
      end
    end else begin
      unique case (strg)
        CBC_ST_CTL_HI: samp_start = rise[0];
        CBC_ST_CTL_LO: samp_start = fall[0];
        CBC_ST_ENBIT: samp_start = en_rise;
        default: samp_start = 1'b0;
      endcase
      if (s_q.samp_run && s_q.samp_cnt == 17'h0_0000) begin
        n.cap1 = count;
        n.diff = count - s_q.cap0;
        dset = cont ? 2'b01 : 2'b10;
        n.samp_run = cont;
        if (cont) begin
          n.cap0 = count;
          n.samp_cnt = {1'b0, s_q.samp_ms} + 17'h0_0001;
        end
      end else if (s_q.samp_run) begin
        if (tick && s_q.samp_cnt != 17'h0_0000) begin
          n.samp_cnt = s_q.samp_cnt - 17'h0_0001;
        end
      end else if (samp_start) begin
        n.cap0 = count;
        n.samp_run = 1'b1;
        n.samp_cnt = {1'b0, s_q.samp_ms} + 17'h0_0001;
      end
    end

    // set wins over refresh clear
    if (io_refresh) begin
      n.stat = s_q.done | dset;
      n.done = 2'b00;
    end else begin
      n.done = s_q.done | dset;
    end

    if (paddr[7:6] == OFS_ITEM_HI2) begin
      case (paddr[3:2])
        2'h0: rd = s_q.lo[idx];
        2'h1: rd = s_q.hi[idx];
        2'h2: rd = s_q.act[idx];
        default: hit = 1'b0;
      endcase
    end else begin
      case (paddr)
        OFS_CTRL: rd = {16'h0000, s_q.ctrl};
        OFS_HOLD: rd = {22'h00_0000, s_q.hold_ms};
        OFS_SAMP: rd = {16'h0000, s_q.samp_ms};
        OFS_STAT: rd = {s_q.flags, 13'h0000, s_q.samp_run, s_q.stat};
        OFS_CAP0: rd = s_q.cap0;
        OFS_CAP1: rd = s_q.cap1;
        OFS_DIFF: rd = s_q.diff;
        OFS_COUNT: rd = count;
        default: hit = 1'b0;
      endcase
    end

    n.rdy = 1'b0;
    n.err = 1'b0;
    if (psel && penable && !s_q.rdy) begin
      n.rdy = 1'b1;
      n.rdata = rd;
      n.err = ~hit;
    end
    if (psel && penable && s_q.rdy && pwrite && !s_q.err) begin
      if (paddr[7:6] == OFS_ITEM_HI2) begin
        case (paddr[3:2])
          2'h0: n.lo[idx] = pwdata;
          2'h1: n.hi[idx] = pwdata;
          2'h2: n.act[idx] = pwdata;
          default: n.rdy = 1'b0;
        endcase
      end else begin
        case (paddr)
          OFS_CTRL: n.ctrl = pwdata[15:0];
          OFS_HOLD: n.hold_ms = (pwdata > 32'(HOLD_MAX_MS)) ? HOLD_MAX_MS
                                                             : pwdata[9:0];
          OFS_SAMP: n.samp_ms = pwdata[15:0];
          default: n.rdy = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= n;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err & s_q.rdy;
  assign ext_out = s_q.ext;
  assign match_flags = s_q.flags;
  assign cap_status = s_q.stat;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_acc_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_acc_wait |=> s_answer)
    else $error("apb answer not after one wait");

  a_band_item_zero: assert property (
    (s_q.ctrl[C_BAND] && in_band[0]) |=>
    ((match_flags & $past(s_q.act[0][31:16]))
     == ($past(s_q.act[0][15:0]) & $past(s_q.act[0][31:16]))))
    else $error("item zero flags not driven");

  a_band_wrap_hit: assert property (
    ($signed(s_q.lo[0]) > $signed(s_q.hi[0]) && count >= $signed(s_q.lo[0]))
    |-> in_band[0])
    else $error("wrapped band missed");

  a_hold_zero_follow: assert property (
    (s_q.hold_ms == 10'h000 && s_q.ctrl[C_ROUTE0] && !s_q.ctrl[C_FEN0])
    |=> (ext_out[0] == match_flags[0]))
    else $error("output not following flag");

  a_force_out_one: assert property (
    s_q.ctrl[C_FEN0 + 2] |=> (ext_out[1] == $past(s_q.ctrl[C_FVAL0 + 2])))
    else $error("forced output wrong");

  a_cap_latch_zero: assert property (
    (!samp && en && cont && trig[0]) |=> (s_q.cap0 == $past(count)))
    else $error("capture zero missed count");

  a_samp_end_store: assert property (
    (samp && s_q.samp_run && s_q.samp_cnt == 17'h0_0000) |=>
    (s_q.cap1 == $past(count) && s_q.diff == $past(count) - $past(s_q.cap0)))
    else $error("sampling result wrong");

  a_samp_blocks_cap: assert property (
    (samp && !s_q.samp_run) |=> $stable(s_q.cap1))
    else $error("capture during sampling mode");

  a_enable_needed: assert property (
    (!samp && !en) |=> ($stable(s_q.cap0) && $stable(s_q.cap1)))
    else $error("capture without enable");

  a_filter_agree: assert property (
    (s_q.lvl != $past(s_q.lvl)) |-> $past(s_q.s2 == s_q.s3))
    else $error("edge taken before agreement");

  a_refresh_status: assert property (
    io_refresh |=> ((cap_status & $past(s_q.done)) == $past(s_q.done)
                    && s_q.done == 2'b00 || $past(trig) != 2'b00))
    else $error("refresh status wrong");

  a_one_shot_once: assert property (
    (!samp && !cont && !s_q.arm[0] && !en_rise) |=> $stable(s_q.cap0))
    else $error("second single-shot capture");

  a_samp_start_cap: assert property (
    (samp && !s_q.samp_run && samp_start) |=> (s_q.samp_run && s_q.cap0 == $past(count)))
    else $error("sampling start missed count");

  a_route_off_low: assert property (
    (!s_q.ctrl[C_ROUTE0 + 1] && !s_q.ctrl[C_FEN0 + 2]) |=> (ext_out[1] == 1'b0))
    else $error("unrouted output driven");

endmodule : cbc_top

/* verif/cbc_sig_src.sv */
// model of the external sources that drive the two control inputs
`timescale 1ns/1ns
module cbc_sig_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [1:0] lvl_req,
  output logic [1:0] ctl_in
);
  logic [3:0][1:0] pipe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[2:0], lvl_req};
    end
  end
  // slow source reaches the pin three cycles later
  assign ctl_in = slow ? pipe_q[3] : pipe_q[0];
endmodule : cbc_sig_src

/* verif/tb_top.sv */
// self-checking bench for the band compare and capture block
`timescale 1ns/1ns
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  import cbc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, io_refresh, pready, pslverr, slow, sl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] lvl_req, ctl_in, ext_out, cap_status;
  logic signed [31:0] count;
  logic [15:0] match_flags;
  int err_count, num_checks;
  cbc_top #(.MS_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_in(ctl_in),
    .count(count), .io_refresh(io_refresh), .ext_out(ext_out),
    .match_flags(match_flags), .cap_status(cap_status));
  cbc_sig_src src (.pclk(pclk), .presetn(presetn), .slow(slow), .lvl_req(lvl_req),
    .ctl_in(ctl_in));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task automatic refresh();
    io_refresh <= 1'b1;
    @(posedge pclk);
    io_refresh <= 1'b0;
    wt(2);
  endtask : refresh
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    wt(5000);
    err_count++;
    test_done();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    io_refresh = 1'b0;
    slow = 1'b0;
    lvl_req = 2'b00;
    count = 32'sh0;
    wt(8);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFS_CTRL, 32'h0, "ctrl_reset");
    rdc(8'h4C, 32'h0, "unmapped_data");
    `CHK("unmapped_err", 1'b1, sl)
    apb(1'b1, OFS_HOLD, 32'h7D0);
    rdc(OFS_HOLD, 32'h3E8, "hold_clamp");
    apb(1'b1, OFS_HOLD, 32'h0);
    // item 0 and item 2 share one band, item 1 wraps over rollover
    apb(1'b1, 8'h40, 32'hA);
    apb(1'b1, 8'h44, 32'h14);
    apb(1'b1, 8'h48, 32'h0001_0001);
    apb(1'b1, 8'h50, 32'h64);
    apb(1'b1, 8'h54, 32'hFFFF_FF9C);
    apb(1'b1, 8'h58, 32'h0002_0002);
    apb(1'b1, 8'h60, 32'hA);
    apb(1'b1, 8'h64, 32'h14);
    apb(1'b1, 8'h68, 32'h0004_0004);
    apb(1'b1, OFS_CTRL, 32'h8200);
    count <= 32'sd15;
    wt(3);
    `CHK("flags_in_band", 16'h0005, match_flags)
    `CHK("ext_follow", 2'b01, ext_out)
    count <= 32'sd200;
    wt(3);
    `CHK("flags_wrap", 16'h0007, match_flags)
    apb(1'b1, OFS_CTRL, 32'h8A00);
    wt(2);
    `CHK("force_off", 2'b00, ext_out)
    apb(1'b1, OFS_CTRL, 32'hE200);
    wt(2);
    `CHK("force_on", 2'b11, ext_out)
    // stretched output: flag 0 set at 15, cleared by item 3 at 35
    apb(1'b1, OFS_HOLD, 32'h2);
    apb(1'b1, 8'h70, 32'h1E);
    apb(1'b1, 8'h74, 32'h28);
    apb(1'b1, 8'h78, 32'h0001_0000);
    apb(1'b1, OFS_CTRL, 32'h8200);
    count <= 32'sd35;
    wt(3);
    `CHK("flag0_off", 1'b0, match_flags[0])
    count <= 32'sd15;
    wt(3);
    `CHK("hold_start", 2'b01, ext_out)
    count <= 32'sd35;
    wt(5);
    `CHK("hold_keep", 2'b01, ext_out)
    wt(40);
    `CHK("hold_end", 2'b00, ext_out)
    // capture 0 on rise, capture 1 on fall of the same input
    apb(1'b1, OFS_CTRL, 32'h0100);
    apb(1'b1, OFS_CTRL, 32'h0101);
    count <= -32'sd100;
    lvl_req <= 2'b01;
    wt(10);
    count <= 32'sd250;
    slow <= 1'b1;
    lvl_req <= 2'b00;
    wt(12);
    count <= 32'sd999;
    lvl_req <= 2'b01;
    wt(12);
    lvl_req <= 2'b00;
    wt(12);
    slow <= 1'b0;
    apb(1'b1, OFS_CAP0, 32'h1234_5678);
    rdc(OFS_CAP0, 32'hFFFF_FF9C, "cap0");
    rdc(OFS_CAP1, 32'hFA, "cap1");
    rdc(OFS_DIFF, 32'h15E, "diff");
    // continuous capture overwrites on every edge
    apb(1'b1, OFS_CTRL, 32'h0105);
    count <= 32'sd500;
    lvl_req <= 2'b01;
    wt(10);
    count <= 32'sd700;
    lvl_req <= 2'b00;
    wt(10);
    rdc(OFS_CAP0, 32'h1F4, "cont_cap0");
    rdc(OFS_CAP1, 32'h2BC, "cont_cap1");
    rdc(OFS_DIFF, 32'hC8, "cont_diff");
    refresh();
    `CHK("status_set", 2'b11, cap_status)
    refresh();
    `CHK("status_clear", 2'b00, cap_status)
    // sampling started by input 0 rising
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_SAMP, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h2);
    count <= 32'sd1000;
    lvl_req <= 2'b01;
    wt(10);
    count <= 32'sd1500;
    wt(60);
    rdc(OFS_CAP0, 32'h3E8, "samp_cap0");
    rdc(OFS_CAP1, 32'h5DC, "samp_cap1");
    rdc(OFS_DIFF, 32'h1F4, "samp_diff");
    refresh();
    `CHK("samp_status", 2'b10, cap_status)
    // sampling started by the enable bit
    lvl_req <= 2'b00;
    apb(1'b1, OFS_CTRL, 32'h12);
    count <= 32'sd3000;
    wt(3);
    apb(1'b1, OFS_CTRL, 32'h13);
    count <= 32'sd3100;
    wt(60);
    rdc(OFS_DIFF, 32'h64, "samp_en_diff");
    refresh();
    `CHK("samp_en_status", 2'b10, cap_status)
    // continuous sampling started by input 0 falling
    lvl_req <= 2'b01;
    wt(8);
    apb(1'b1, OFS_CTRL, 32'hE);
    count <= 32'sd4000;
    lvl_req <= 2'b00;
    wt(8);
    rdc(OFS_CAP0, 32'hFA0, "cont_samp_cap0");
    count <= 32'sd4200;
    wt(60);
    rdc(OFS_CAP1, 32'h1068, "cont_samp_cap1");
    refresh();
    `CHK("cont_samp_status", 2'b01, cap_status)
    test_done();
  end
endmodule : tb_top
